// >>> pwr_pkg.sv
// Constants for the pause-control and power-event register bank.
// Assumes a 32-bit Wishbone slave at the core clock of 25 MHz.
// Overview of operation
// - Pause-low flag sets on nonzero low pause; clears on timer zero or new pause frame.
// - Paused flag sets on nonzero pause; clears when pause timer reaches zero.
// - Receive-full flag reads our pause request (threshold, descriptor or force) only while pause-sent is high.
// - Writing one to force-pause raises pause request, as if the FIFO were full.
// - Force-pause reads one from raise by write or descriptor until release.
// - Writing one to release-pause drops a forced pause request, not one from FIFO level; release bit always reads zero.
// - Pause frame requested when receive FIFO free space falls to threshold level.
// - Threshold 000 is 0.5 KB, 001 is 1 KB, then quarter-KB steps to 2.5 KB.
// - Link-change flag sets on link status change; write one clears it.
// - Wake-pattern flag sets on wake frame regardless of enables; write one clears.
// - Matched-frame flag sets on packet filter match; write one clears it.
// - Sideband-ready is read/write, reset zero, and drives the sideband ready signal.
// - Sideband-request reads one while busy with sideband frames; resets zero.
// - Wake-event bit mirrors PM status, set on wake; write one clears it and pin.
// - Power-event byte reset only by alternate reset, not by bus reset, except sideband-request, which bus reset clears.
package pwr_pkg;

  // ***********************************************************
  // Register map
  // ***********************************************************
  localparam logic [7:0] PWR_PAUSE_CONTROL_STATUS_OFS = 8'h18;
  localparam logic [7:0] PWR_POWER_EVENT_FLAGS_OFS    = 8'h18;

  // ***********************************************************
  // Bit positions inside the dword
  // ***********************************************************
  localparam int PWR_LINK_CHANGE_BIT    = 31;
  localparam int PWR_WAKE_PATTERN_BIT   = 30;
  localparam int PWR_MATCHED_FRAME_BIT  = 29;
  localparam int PWR_SB_READY_BIT       = 27;
  localparam int PWR_SB_REQUEST_BIT     = 25;
  localparam int PWR_WAKE_EVENT_BIT     = 24;
  localparam int PWR_PAUSE_LOW_BIT      = 20;
  localparam int PWR_PAUSED_BIT         = 19;
  localparam int PWR_RX_FULL_BIT        = 18;
  localparam int PWR_FORCE_PAUSE_BIT    = 17;
  localparam int PWR_RELEASE_PAUSE_BIT  = 16;
  localparam int PWR_THRESH_LSB         = 8;
  localparam int PWR_THRESH_W           = 3;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [2:0] PWR_THRESH_RST     = 3'h0;
  localparam logic [7:0] PWR_EVENT_BYTE_RST = 8'h00;

  // ***********************************************************
  // Threshold encoding, free bytes
  // ***********************************************************
  localparam int PWR_THRESH_BASE_BYTES = 512;
  localparam int PWR_THRESH_ONE_BYTES  = 1024;
  localparam int PWR_THRESH_STEP_BYTES = 256;

endpackage : pwr_pkg

// >>> pwr_pause_level.sv
// Threshold decoder and free-space comparator for the pause request.
// Assumes free-space count comes from receive FIFO logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module pwr_pause_level #(
  parameter int FREE_W = 13
) (
  input  wire logic [2:0]        level,
  input  wire logic [FREE_W-1:0] freeBytes,
  output logic                   atLevel
);

  logic [FREE_W-1:0] limitBytes;

  // Elaboration check: the top level needs twelve bits
  if (FREE_W < 12)
  begin : g_free_w_check
    $error("pwr_pause_level: FREE_W too narrow for 2.5 KB");
  end

  // ***********************************************************
  // Level decode
  // ***********************************************************
  always_comb
  begin
    if (level == 3'h0)
      limitBytes = FREE_W'(pwr_pkg::PWR_THRESH_BASE_BYTES);
    else
      limitBytes = FREE_W'(pwr_pkg::PWR_THRESH_ONE_BYTES
                   + (int'(level) - 1) * pwr_pkg::PWR_THRESH_STEP_BYTES);
  end

  assign atLevel = (freeBytes <= limitBytes);

endmodule // pwr_pause_level
`default_nettype wire

// >>> pwr_pause_wake_regs.sv
// Pause control/status and power-event bytes of one control dword.
// Assumes a classic Wishbone master on clock, event strobes from the MAC.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module pwr_pause_wake_regs #(
  parameter int FREE_W  = 13,
  parameter int TIMER_W = 16
) (
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic               altRstn,
  // Wishbone slave
  input  wire logic               wbCyc,
  input  wire logic               wbStb,
  input  wire logic               wbWe,
  input  wire logic [7:0]         wbAdr,
  input  wire logic [3:0]         wbSel,
  input  wire logic [31:0]        wbDatIn,
  output logic [31:0]             wbDatOut,
  output logic                    wbAck,
  // Pause frame events from the receive MAC
  input  wire logic               pauseRx,
  input  wire logic               pauseRxLow,
  input  wire logic [TIMER_W-1:0] pauseRxValue,
  input  wire logic               pauseTick,
  input  wire logic               descriptorPauseFlag,
  input  wire logic [FREE_W-1:0]  rxFreeBytes,
  input  wire logic               pauseSent,
  output logic                    pauseRequest,
  output logic                    macPaused,
  // Wake and status events
  input  wire logic               linkStatus,
  input  wire logic               wakePatternRx,
  input  wire logic               filterMatchRx,
  input  wire logic               wakeEventIn,
  input  wire logic               sidebandBusy,
  output logic                    sidebandReady,
  output logic                    wakeStatusClear,
  output logic                    wakeOutputPin
);

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    logic               ack;
    logic [31:0]        rdata;
    logic [TIMER_W-1:0] timer;
    logic               pausedFlag;
    logic               pauseLowActive;
    logic               forceReq;
    logic [2:0]         level;
    logic               linkSync1;
    logic               linkSync2;
    logic               linkPrev;
    logic [2:0]         linkWarm;
    logic               busySync1;
    logic               busySync2;
    logic               clrPulse;
  } pwr_core_t;

  typedef struct packed {
    logic linkChange;
    logic wakePattern;
    logic matchedFrame;
    logic sbReady;
    logic wakeEvent;
  } pwr_event_t;

  pwr_core_t  r;
  pwr_core_t  next_r;
  pwr_event_t e;
  pwr_event_t next_e;

  logic       atLevel;
  logic       access;
  logic       hit;
  logic       wrHi;
  logic       wrMid;
  logic       wrTop;
  logic       rxFull;
  logic [31:0] readWord;

  if (TIMER_W < 1)
  begin : g_timer_w_check
    $error("pwr_pause_wake_regs: TIMER_W must be positive");
  end

  pwr_pause_level #(
    .FREE_W    (FREE_W)
  ) u_level (
    .level     (r.level),
    .freeBytes (rxFreeBytes),
    .atLevel   (atLevel)
  );

  // ***********************************************************
  // Bus decode
  // ***********************************************************
  assign access = wbCyc && wbStb && !r.ack;
  assign hit    = (wbAdr == pwr_pkg::PWR_PAUSE_CONTROL_STATUS_OFS);
  assign wrMid  = access && hit && wbWe && wbSel[1];
  assign wrHi   = access && hit && wbWe && wbSel[2];
  assign wrTop  = access && hit && wbWe && wbSel[3];

  // Request held while forced, descriptor-raised, or FIFO at level
  assign rxFull = r.forceReq || atLevel;

  always_comb
  begin
    readWord = 32'h0000_0000;
    readWord[pwr_pkg::PWR_LINK_CHANGE_BIT]   = e.linkChange;
    readWord[pwr_pkg::PWR_WAKE_PATTERN_BIT]  = e.wakePattern;
    readWord[pwr_pkg::PWR_MATCHED_FRAME_BIT] = e.matchedFrame;
    readWord[pwr_pkg::PWR_SB_READY_BIT]      = e.sbReady;
    readWord[pwr_pkg::PWR_SB_REQUEST_BIT]    = r.busySync2;
    readWord[pwr_pkg::PWR_WAKE_EVENT_BIT]    = e.wakeEvent;
    readWord[pwr_pkg::PWR_PAUSE_LOW_BIT]     = r.pauseLowActive;
    readWord[pwr_pkg::PWR_PAUSED_BIT]        = r.pausedFlag;
    readWord[pwr_pkg::PWR_RX_FULL_BIT]       = rxFull && pauseSent;
    readWord[pwr_pkg::PWR_FORCE_PAUSE_BIT]   = r.forceReq;
    readWord[pwr_pkg::PWR_THRESH_LSB +: pwr_pkg::PWR_THRESH_W] = r.level;
  end

  // ***********************************************************
  // Core next state
  // ***********************************************************
  always_comb
  begin
    next_r = r;
    next_r.ack = access;
    next_r.clrPulse = 1'b0;
    if (access)
      next_r.rdata = hit ? readWord : 32'h0000_0000;
    if (wrMid)
      next_r.level = wbDatIn[pwr_pkg::PWR_THRESH_LSB +: pwr_pkg::PWR_THRESH_W];
    // Release wins over a same-cycle force write or descriptor flag
    if (descriptorPauseFlag)
      next_r.forceReq = 1'b1;
    if (wrHi && wbDatIn[pwr_pkg::PWR_FORCE_PAUSE_BIT])
      next_r.forceReq = 1'b1;
    if (wrHi && wbDatIn[pwr_pkg::PWR_RELEASE_PAUSE_BIT])
      next_r.forceReq = 1'b0;
    // Pause timer
    if (pauseRx)
    begin
      next_r.timer = pauseRxValue;
      next_r.pausedFlag = (pauseRxValue != '0);
      next_r.pauseLowActive = pauseRxLow && (pauseRxValue != '0);
    end
    else if (r.pausedFlag && pauseTick)
    begin
      next_r.timer = r.timer - TIMER_W'(1);
      if (r.timer == TIMER_W'(1))
      begin
        next_r.pausedFlag = 1'b0;
        next_r.pauseLowActive = 1'b0;
      end
    end
    next_r.linkSync1 = linkStatus;
    next_r.linkSync2 = r.linkSync1;
    next_r.linkPrev  = r.linkSync2;
    next_r.linkWarm  = {r.linkWarm[1:0], 1'b1};
    next_r.busySync1 = sidebandBusy;
    next_r.busySync2 = r.busySync1;
    if (wrTop && wbDatIn[pwr_pkg::PWR_WAKE_EVENT_BIT])
      next_r.clrPulse = 1'b1;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.level <= pwr_pkg::PWR_THRESH_RST;
    end
    else
      r <= next_r;
  end

  // ***********************************************************
  // Power-event byte, set wins over clear
  // ***********************************************************
  always_comb
  begin
    next_e = e;
    if (wrTop)
    begin
      if (wbDatIn[pwr_pkg::PWR_LINK_CHANGE_BIT])
        next_e.linkChange = 1'b0;
      if (wbDatIn[pwr_pkg::PWR_WAKE_PATTERN_BIT])
        next_e.wakePattern = 1'b0;
      if (wbDatIn[pwr_pkg::PWR_MATCHED_FRAME_BIT])
        next_e.matchedFrame = 1'b0;
      if (wbDatIn[pwr_pkg::PWR_WAKE_EVENT_BIT])
        next_e.wakeEvent = 1'b0;
      next_e.sbReady = wbDatIn[pwr_pkg::PWR_SB_READY_BIT];
    end
    // Sync chain refills after a bus reset; a link already up is no change
    if (r.linkWarm[2] && (r.linkSync2 != r.linkPrev))
      next_e.linkChange = 1'b1;
    if (wakePatternRx)
      next_e.wakePattern = 1'b1;
    if (filterMatchRx)
      next_e.matchedFrame = 1'b1;
    if (wakeEventIn)
      next_e.wakeEvent = 1'b1;
  end

  // Only the alternate reset clears this byte
  always_ff @(posedge clock or negedge altRstn)
  begin
    if (!altRstn)
      e <= '0;
    else
      e <= next_e;
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign wbAck           = r.ack;
  assign wbDatOut        = r.rdata;
  assign pauseRequest    = rxFull;
  assign macPaused       = r.pausedFlag;
  assign sidebandReady   = e.sbReady;
  assign wakeStatusClear = r.clrPulse;
  assign wakeOutputPin   = e.wakeEvent;

endmodule // pwr_pause_wake_regs
`default_nettype wire

// >>> pwr_regs_monitor.sv
// Port-level checker for the pause and wake register bank.
// Assumes a bind onto pwr_pause_wake_regs; one clock, bus reset rstn.
`timescale 1ns/100ps
`default_nettype none
module pwr_regs_monitor #(
  parameter int FREE_W = 13
) (
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic              wbCyc,
  input wire logic              wbStb,
  input wire logic              wbWe,
  input wire logic [7:0]        wbAdr,
  input wire logic [3:0]        wbSel,
  input wire logic [31:0]       wbDatIn,
  input wire logic [31:0]       wbDatOut,
  input wire logic              wbAck,
  input wire logic              descriptorPauseFlag,
  input wire logic [FREE_W-1:0] rxFreeBytes,
  input wire logic              pauseRequest,
  input wire logic              wakeEventIn,
  input wire logic              sidebandReady,
  input wire logic              wakeStatusClear,
  input wire logic              wakeOutputPin
);
  // ***********************************************************
  // Bus and register properties
  // ***********************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic wrHit;
  assign wrHit = wbAck && wbWe && wbAdr == 8'h18;
  AST_ACK_NEXT: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wbAck |-> $past(wbCyc && wbStb)) else $error("ack unasked");
  AST_RELEASE_RD0: assert property (wbAck && !wbWe |-> !wbDatOut[16])
    else $error("release bit read back one");
  AST_RSVD_ZERO: assert property (wbAck && !wbWe |-> (wbDatOut & 32'h14e0_f8ff) == 32'h0)
    else $error("reserved bits read nonzero");
  AST_SB_READY: assert property (wbAck && !wbWe && wbAdr == 8'h18
    |-> wbDatOut[27] == sidebandReady) else $error("sideband ready differs from bit");
  AST_FORCE: assert property (wrHit && wbSel[2] && wbDatIn[17] && !wbDatIn[16]
    |-> ##1 pauseRequest) else $error("force write left pause request low");
  // Free space at or below the top level or a descriptor flag may hold the request
  AST_RELEASE: assert property (wrHit && wbSel[2] && wbDatIn[16] && !descriptorPauseFlag
    |-> ##1 (!pauseRequest || rxFreeBytes <= 13'h0a00))
    else $error("release write left pause request high");
  AST_WAKE_PIN: assert property (wakeEventIn |=> wakeOutputPin)
    else $error("wake event did not raise pin");
  AST_WAKE_CLR: assert property (wrHit && wbSel[3] && wbDatIn[24]
    |-> ##[0:1] wakeStatusClear) else $error("no status clear pulse");
endmodule // pwr_regs_monitor
`default_nettype wire

// >>> pause_and_wake_status_regs_tb.sv
// Self-checking bench for the pause and wake register bank.
// Assumes pwr_pkg, the design and the monitor are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module pause_and_wake_status_regs_tb;
  // ***********************************************************
  // Stimulus and checks
  // ***********************************************************
  logic        clock = 0, rstn = 0, altRstn = 0, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck;
  logic        pauseRx = 0, pauseRxLow = 0, pauseTick = 0, descriptorPauseFlag = 0;
  logic        pauseSent = 0, linkStatus = 0, wakePatternRx = 0, filterMatchRx = 0;
  logic        wakeEventIn = 0, sidebandBusy = 0, pauseRequest, macPaused;
  logic        sidebandReady, wakeStatusClear, wakeOutputPin;
  logic [7:0]  wbAdr = 0;
  logic [3:0]  wbSel = 0;
  logic [31:0] wbDatIn = 0, wbDatOut, rd;
  logic [15:0] pauseRxValue = 0;
  logic [12:0] rxFreeBytes = 13'h1fff;
  int          error_cnt = 0, checked = 0;
  pwr_pause_wake_regs u_dut (.clock(clock), .rstn(rstn), .altRstn(altRstn), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
    .wbDatOut(wbDatOut), .wbAck(wbAck), .pauseRx(pauseRx), .pauseRxLow(pauseRxLow),
    .pauseRxValue(pauseRxValue), .pauseTick(pauseTick), .descriptorPauseFlag(descriptorPauseFlag),
    .rxFreeBytes(rxFreeBytes), .pauseSent(pauseSent), .pauseRequest(pauseRequest),
    .macPaused(macPaused), .linkStatus(linkStatus), .wakePatternRx(wakePatternRx),
    .filterMatchRx(filterMatchRx), .wakeEventIn(wakeEventIn), .sidebandBusy(sidebandBusy),
    .sidebandReady(sidebandReady), .wakeStatusClear(wakeStatusClear),
    .wakeOutputPin(wakeOutputPin));
  always #20 clock = ~clock;
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Values read right after an edge are those sampled at that edge
  task wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= s;
    wbDatIn <= d;
    do
      @(posedge clock);
    while (wbAck !== 1'b1 && ++n < 20);
    `CHK(wbAck, 1'b1)
    rd = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task wr(input logic [3:0] s, input logic [31:0] d);
    wb(1'b1, 8'h18, s, d);
  endtask
  task rdr();
    wb(1'b0, 8'h18, 4'hf, 32'h0);
  endtask
  task pz(input logic lo, input logic [15:0] v);
    @(posedge clock);
    pauseRx <= 1'b1;
    pauseRxLow <= lo;
    pauseRxValue <= v;
    @(posedge clock);
    pauseRx <= 1'b0;
  endtask
  task tk(input int n);
    repeat (n)
    begin
      @(posedge clock);
      pauseTick <= 1'b1;
      @(posedge clock);
      pauseTick <= 1'b0;
    end
  endtask
  task t_reset();
    rdr();
    `CHK(rd, 32'h0)
    wb(1'b1, 8'h1c, 4'hf, 32'hffff_ffff);
    rdr();
    `CHK(rd, 32'h0)
    $display("test reset done");
  endtask
  task t_level();
    int lv;
    for (int k = 0; k < 8; k++)
    begin
      lv = (k == 0) ? pwr_pkg::PWR_THRESH_BASE_BYTES
         : pwr_pkg::PWR_THRESH_ONE_BYTES + (k - 1) * pwr_pkg::PWR_THRESH_STEP_BYTES;
      wr(4'b0010, {21'h0, 3'(k), 8'h0});
      rdr();
      `CHK(rd[10:8], 3'(k))
      rxFreeBytes <= 13'(lv + 1);
      tick(2);
      `CHK(pauseRequest, 1'b0)
      rxFreeBytes <= 13'(lv);
      tick(2);
      `CHK(pauseRequest, 1'b1)
    end
    rxFreeBytes <= 13'h1fff;
    wr(4'b0010, 32'h0);
    $display("test level done");
  endtask
  task t_force();
    wr(4'b0100, 32'h0002_0000);
    pauseSent <= 1'b1;
    rdr();
    `CHK(rd[18:16], 3'b110)
    `CHK(pauseRequest, 1'b1)
    wr(4'b0100, 32'h0001_0000);
    rdr();
    `CHK(rd[18:16], 3'b000)
    @(posedge clock);
    descriptorPauseFlag <= 1'b1;
    @(posedge clock);
    descriptorPauseFlag <= 1'b0;
    rdr();
    `CHK(rd[17], 1'b1)
    wr(4'b0100, 32'h0003_0000);
    rdr();
    `CHK(rd[17], 1'b0)
    pauseSent <= 1'b0;
    $display("test force done");
  endtask
  task t_pause();
    pz(1'b1, 16'h0002);
    rdr();
    `CHK(rd[20:19], 2'b11)
    tk(1);
    `CHK(macPaused, 1'b1)
    tk(1);
    rdr();
    `CHK(rd[20:19], 2'b00)
    pz(1'b1, 16'h0003);
    pz(1'b0, 16'h0003);
    rdr();
    `CHK(rd[20:19], 2'b01)
    tk(3);
    tick(1);
    `CHK(macPaused, 1'b0)
    pz(1'b0, 16'h0000);
    rdr();
    `CHK(rd[19], 1'b0)
    $display("test pause done");
  endtask
  task t_events();
    @(posedge clock);
    {wakePatternRx, filterMatchRx, wakeEventIn, linkStatus} <= 4'hf;
    @(posedge clock);
    {wakePatternRx, filterMatchRx, wakeEventIn} <= 3'h0;
    tick(6);
    linkStatus <= 1'b0;
    tick(6);
    rdr();
    `CHK(rd[31:24], 8'he1)
    `CHK(wakeOutputPin, 1'b1)
    wr(4'b1100, 32'hf5dc_0000);
    rdr();
    `CHK(rd[31:16], 16'h0)
    `CHK(wakeOutputPin, 1'b0)
    $display("test events done");
  endtask
  task t_side();
    wr(4'b1000, 32'h0800_0000);
    `CHK(sidebandReady, 1'b1)
    sidebandBusy <= 1'b1;
    tick(5);
    rdr();
    `CHK(rd[27:25], 3'b101)
    sidebandBusy <= 1'b0;
    wr(4'b1000, 32'h0);
    tick(5);
    rdr();
    `CHK(rd[27:25], 3'b000)
    $display("test sideband done");
  endtask
  task t_alt();
    @(posedge clock);
    wakePatternRx <= 1'b1;
    linkStatus <= 1'b1;
    @(posedge clock);
    wakePatternRx <= 1'b0;
    tick(6);
    wr(4'b1010, 32'h8000_0500);
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    tick(4);
    rdr();
    `CHK(rd[31:24], 8'h40)
    `CHK(rd[10:8], 3'h0)
    altRstn <= 1'b0;
    tick(2);
    altRstn <= 1'b1;
    rdr();
    `CHK(rd[31:24], 8'h00)
    $display("test reset split done");
  endtask
  task tally_and_finish();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    tick(3);
    rstn <= 1'b1;
    altRstn <= 1'b1;
    t_reset();
    t_level();
    t_force();
    t_pause();
    t_events();
    t_side();
    t_alt();
    tally_and_finish();
  end
  // Run needs about 220 cycles
  initial
  begin
    tick(5000);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule // pause_and_wake_status_regs_tb
bind pwr_pause_wake_regs pwr_regs_monitor #(.FREE_W(FREE_W)) u_mon (.clock(clock), .rstn(rstn),
  .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
  .wbDatOut(wbDatOut), .wbAck(wbAck), .descriptorPauseFlag(descriptorPauseFlag),
  .rxFreeBytes(rxFreeBytes), .pauseRequest(pauseRequest), .wakeEventIn(wakeEventIn),
  .sidebandReady(sidebandReady), .wakeStatusClear(wakeStatusClear), .wakeOutputPin(wakeOutputPin));
`default_nettype wire
